/* common/vmc_pkg.sv */
// Constants and register layouts of the voltage-mode chopper configuration block.
// Assumes a 200 MHz core clock and a 32-bit classic Wishbone register port.
package vmc_pkg;

  localparam int          WB_AW  = 8;
  localparam int          WB_DW  = 32;
  localparam int          BYTE_W = 8;
  localparam int          AMP_W  = 8;
  localparam int          PER_W  = 11;

  // Register byte addresses
  localparam logic [7:0]  ADR_GLOBAL_CONFIG = 8'h00;
  localparam logic [7:0]  ADR_HOLD  = 8'h04;
  localparam logic [7:0]  ADR_SPEED = 8'h08;
  localparam logic [7:0]  ADR_PWM   = 8'h0c;
  localparam logic [7:0]  ADR_CHOP  = 8'h10;
  localparam logic [7:0]  ADR_STAT  = 8'h14;
  localparam logic [7:0]  ADR_RDBK  = 8'h18;

  // Timing
  localparam int          CLK_MHZ       = 200;
  localparam int          DLY_TICK_US   = 1;
  localparam int          DLY_TICK_CYC  = DLY_TICK_US * CLK_MHZ;
  localparam logic [7:0]  DLY_TICK_LAST = 8'(DLY_TICK_CYC - 1);
  localparam logic [5:0]  BLANK_BASE    = 6'h10;
  localparam logic [5:0]  BLANK_STEP    = 6'h08;
  localparam logic [10:0] PWM_PER [4]   = '{11'h400, 11'h2ab, 11'h200, 11'h19a};

  // Amplitude arithmetic
  localparam int          VEL_SHIFT = 8;
  localparam logic [3:0]  LIM_LOW   = 4'hf;
  localparam logic [7:0]  AMP_MAX   = 8'hff;
  localparam logic [8:0]  SCALE_MAX = 9'h1fe;

  // Standstill options
  localparam logic [1:0]  SS_OPT_NORMAL = 2'h0;
  localparam logic [1:0]  SS_OPT_LS     = 2'h2;
  localparam logic [1:0]  SS_OPT_HS     = 2'h3;

  // Reset values
  localparam logic [4:0]  HOLD_CUR_RST = 5'h10;
  localparam logic [3:0]  RAMP_DLY_RST = 4'h1;
  localparam logic [7:0]  PDN_DLY_RST  = 8'h14;
  localparam logic [7:0]  OFS_RST      = 8'h24;
  localparam logic [3:0]  GAIN_RST     = 4'h4;
  localparam logic [3:0]  LIM_RST      = 4'hc;
  localparam logic [3:0]  SLOW_DECAY_TIME_RST     = 4'h3;
  localparam logic [1:0]  TBL_RST      = 2'h2;

  typedef struct packed {
    logic [28:0] rsvd;
    logic        autograd;
    logic        autoscale;
    logic        cur_mode_sel;
  } vmc_global_config_t;

  typedef struct packed {
    logic [7:0] rsvd_h;
    logic [7:0] powerdown_delay;
    logic [3:0] rsvd_m;
    logic [3:0] hold_ramp_delay;
    logic [2:0] rsvd_l;
    logic [4:0] hold_current;
  } vmc_hold_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic [19:0] limit;
  } vmc_speed_t;

  typedef struct packed {
    logic [3:0] switch_amplitude_limit;
    logic [3:0] reg_gain;
    logic [1:0] rsvd_h;
    logic [1:0] standstill_option;
    logic [1:0] rsvd_l;
    logic [1:0] pwm_rate_select;
    logic [7:0] amplitude_gradient;
    logic [7:0] amplitude_offset;
  } vmc_pwm_t;

  typedef struct packed {
    logic [25:0] rsvd;
    logic [1:0]  blanking_select;
    logic [3:0]  slow_decay_time;
  } vmc_chop_t;

  typedef struct packed {
    logic [8:0]  rsvd;
    logic        standstill_applied;
    logic        voltage_mode;
    logic        limit_active;
    logic [19:0] microstep_interval;
  } vmc_stat_t;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] tuned_gradient_readback;
    logic [7:0] tuned_offset_readback;
    logic [7:0] scale_readback;
  } vmc_rdbk_t;

  typedef struct packed {
    vmc_global_config_t global_config;
    vmc_hold_t  hold;
    vmc_speed_t speed;
    vmc_pwm_t   pwm;
    vmc_chop_t  chop;
  } vmc_cfg_t;

  typedef enum logic [1:0] {SS_RUN, SS_WAIT, SS_APPLY} vmc_ss_t;

endpackage

/* core/vmc_chopper_cfg.sv */
// Voltage-mode chopper configuration, standstill control and PWM core.
// Assumes a Wishbone classic master and synchronous motor-side inputs.
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Function
// [RQ1] Standstill option acts only while hold current setting is zero.
// [RQ2] Option takes effect after powerdown plus hold ramp delay.
// [RQ3] Regulation state freezes while target current is zero.
// [RQ4] Chopper select is register bit XOR pin; one disables voltage mode.
// [RQ5] Voltage mode off while microstep interval below speed limit.
// [RQ6] On switch to voltage mode amplitude limited by 4-bit upper limit.
// [RQ7] Autoscale bit chooses velocity-based or regulated amplitude.
// [RQ8] Autograd bit enables gradient tuning, else user gradient used.
// [RQ9] Rate select gives chopper frequency 2/1024..2/410 of clock; the up-counting period gives 1/1024..1/410.
// [RQ10] Gain 1..15 moves scale 0.5..7.5 steps per fullstep.
// [RQ11] Offset sets velocity-mode offset and seeds tuned offset.
// [RQ12] Gradient sets velocity gradient, seeds tuning, reset from OTP.
// [RQ13] Option: normal, standstill_option, low-side short, high-side short.
// [RQ14] Scale readback frozen while current-mode chopper runs.
// [RQ15] Tuned values read back; cleared bits reload user values.
// [RQ16] Slow decay time zero turns driver off, nonzero enables it.
// [RQ17] Comparator blanked 16/24/32/40 clocks after each switch.
// [RQ18] Parameter changes take effect at the next chopper period.
module vmc_chopper_cfg
  import vmc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [WB_DW-1:0] wb_dat_i,
  output logic      [WB_DW-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             chop_sel_pin,
  input  wire logic [19:0]      microstep_interval,
  input  wire logic             motor_standstill,
  input  wire logic             fullstep_pulse,
  input  wire logic             target_current_zero,
  input  wire logic             current_below_target,
  input  wire logic             comparator_raw,
  input  wire logic [7:0]       otp_gradient,
  output logic                  pwm_out,
  output logic                  bridge_enable,
  output logic                  low_side_short,
  output logic                  high_side_short,
  output logic                  voltage_mode_active,
  output logic                  comparator_valid
);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  vmc_cfg_t         cfg_reg, cfg_next;
  logic             otp_done_reg;
  logic             ack_next;
  logic [WB_DW-1:0] rd_next;
  logic             wb_req, wr_en;
  vmc_stat_t        stat;
  vmc_rdbk_t        rdbk;
  vmc_ss_t          ss_reg, ss_next;
  logic [8:0]       scale_reg, scale_next;
  logic [7:0]       tofs_reg, tofs_next, tgrad_reg, tgrad_next;
  logic             lim_act_reg, lim_act_next;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_en  = wb_req && wb_we_i && wb_ack_o;

  function automatic logic [WB_DW-1:0] wmask(input logic [WB_DW-1:0] old,
                                             input logic [WB_DW-1:0] d,
                                             input logic [3:0] sel);
    wmask = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) wmask[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
    end
  endfunction

  // Status and readback words
  always_comb begin
    stat = '0;
    stat.standstill_applied = (ss_reg == SS_APPLY);
    stat.voltage_mode       = voltage_mode_active;
    stat.limit_active       = lim_act_reg;
    stat.microstep_interval = microstep_interval;
    rdbk = '0;
    rdbk.scale_readback          = scale_reg[8:1]; // [RQ14]
    rdbk.tuned_offset_readback   = tofs_reg;       // [RQ15]
    rdbk.tuned_gradient_readback = tgrad_reg;
  end

  // Register writes, OTP gradient load, read mux
  always_comb begin
    cfg_next = cfg_reg;
    ack_next = wb_req && !wb_ack_o;
    rd_next  = wb_dat_o;
    if (!otp_done_reg) cfg_next.pwm.amplitude_gradient = otp_gradient; // [RQ12]
    if (wr_en) begin
      case (wb_adr_i)
        ADR_GLOBAL_CONFIG: cfg_next.global_config = wmask(cfg_reg.global_config, wb_dat_i, wb_sel_i);
        ADR_HOLD:  cfg_next.hold  = wmask(cfg_reg.hold, wb_dat_i, wb_sel_i);
        ADR_SPEED: cfg_next.speed = wmask(cfg_reg.speed, wb_dat_i, wb_sel_i);
        ADR_PWM:   cfg_next.pwm   = wmask(cfg_reg.pwm, wb_dat_i, wb_sel_i);
        ADR_CHOP:  cfg_next.chop  = wmask(cfg_reg.chop, wb_dat_i, wb_sel_i);
        default:   ;
      endcase
    end
    cfg_next.global_config.rsvd  = '0;
    cfg_next.hold.rsvd_h = '0;
    cfg_next.hold.rsvd_m = '0;
    cfg_next.hold.rsvd_l = '0;
    cfg_next.speed.rsvd  = '0;
    cfg_next.pwm.rsvd_h  = '0;
    cfg_next.pwm.rsvd_l  = '0;
    cfg_next.chop.rsvd   = '0;
    if (wb_req && !wb_ack_o) begin
      case (wb_adr_i)
        ADR_GLOBAL_CONFIG: rd_next = cfg_reg.global_config;
        ADR_HOLD:  rd_next = cfg_reg.hold;
        ADR_SPEED: rd_next = cfg_reg.speed;
        ADR_PWM:   rd_next = cfg_reg.pwm;
        ADR_CHOP:  rd_next = cfg_reg.chop;
        ADR_STAT:  rd_next = stat;
        ADR_RDBK:  rd_next = rdbk;
        default:   rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= '{global_config: '{rsvd: '0, autograd: 1'b1, autoscale: 1'b1,
                            cur_mode_sel: 1'b0},
                   hold:  '{rsvd_h: '0, powerdown_delay: PDN_DLY_RST,
                            rsvd_m: '0, hold_ramp_delay: RAMP_DLY_RST,
                            rsvd_l: '0, hold_current: HOLD_CUR_RST},
                   speed: '0,
                   pwm:   '{switch_amplitude_limit: LIM_RST,
                            reg_gain: GAIN_RST, rsvd_h: '0,
                            standstill_option: SS_OPT_NORMAL, rsvd_l: '0,
                            pwm_rate_select: '0, amplitude_gradient: '0,
                            amplitude_offset: OFS_RST},
                   chop:  '{rsvd: '0, blanking_select: TBL_RST,
                            slow_decay_time: SLOW_DECAY_TIME_RST}};
      otp_done_reg <= 1'b0;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= '0;
    end else begin
      cfg_reg      <= cfg_next;
      otp_done_reg <= 1'b1;
      wb_ack_o     <= ack_next;
      wb_dat_o     <= rd_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and standstill sequencing
  // ----------------------------------------------------------------
  logic       vm_next, drv_en, applied, run;
  logic [7:0] tick_reg, tick_next;
  logic [8:0] dly_reg, dly_next;
  logic       tick;

  assign drv_en  = (cfg_reg.chop.slow_decay_time != '0); // [RQ16]
  assign tick    = (tick_reg == DLY_TICK_LAST);
  assign applied = (ss_reg == SS_APPLY) && voltage_mode_active &&
                   (cfg_reg.pwm.standstill_option != SS_OPT_NORMAL); // [RQ13]
  assign run     = voltage_mode_active && drv_en && !applied;

  always_comb begin
    vm_next = !(cfg_reg.global_config.cur_mode_sel ^ chop_sel_pin) &&     // [RQ4]
              !(microstep_interval < cfg_reg.speed.limit);        // [RQ5]
    tick_next = tick ? '0 : tick_reg + 8'h01;
    ss_next   = ss_reg;
    dly_next  = dly_reg;
    if (!motor_standstill || cfg_reg.hold.hold_current != '0) begin // [RQ1]
      ss_next = SS_RUN;
    end else begin
      unique case (ss_reg)
        SS_RUN: begin
          ss_next  = SS_WAIT;
          tick_next = '0;                                         // [RQ2] Whole first tick
          dly_next = 9'(cfg_reg.hold.powerdown_delay) +
                     9'(cfg_reg.hold.hold_ramp_delay);             // [RQ2]
        end
        SS_WAIT: begin
          if (dly_reg == '0) ss_next = SS_APPLY;                  // [RQ2]
          else if (tick) dly_next = dly_reg - 9'h001;
        end
        SS_APPLY: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      voltage_mode_active <= 1'b0;
      tick_reg            <= '0;
      ss_reg              <= SS_RUN;
      dly_reg             <= '0;
    end else begin
      voltage_mode_active <= vm_next;
      tick_reg            <= tick_next;
      ss_reg              <= ss_next;
      dly_reg             <= dly_next;
    end
  end

  // ----------------------------------------------------------------
  // Amplitude regulation and tuning
  // ----------------------------------------------------------------
  logic        reg_upd, up;
  logic [9:0]  scale_up;
  logic [7:0]  gsel, osel, amp, lim_val;
  logic [19:0] gterm;
  logic [20:0] amp_sum;

  assign reg_upd = fullstep_pulse && voltage_mode_active &&
                   !target_current_zero;                         // [RQ3] [RQ14]
  assign up      = current_below_target;
  assign scale_up = 10'(scale_reg) + 10'(cfg_reg.pwm.reg_gain);
  assign lim_val = {cfg_reg.pwm.switch_amplitude_limit, LIM_LOW};

  function automatic logic [7:0] step8(input logic [7:0] v, input logic inc);
    step8 = inc ? ((v == AMP_MAX) ? v : v + 8'h01) : ((v == '0) ? v : v - 8'h01);
  endfunction

  always_comb begin
    scale_next   = scale_reg;
    tofs_next    = tofs_reg;
    tgrad_next   = tgrad_reg;
    lim_act_next = lim_act_reg;
    // Gain counts half steps of the scale value
    if (reg_upd && cfg_reg.global_config.autoscale) begin                  // [RQ10]
      if (up) scale_next = (scale_up > 10'(SCALE_MAX)) ? SCALE_MAX : scale_up[8:0];
      else scale_next = (scale_reg < 9'(cfg_reg.pwm.reg_gain)) ? '0 :
                        scale_reg - 9'(cfg_reg.pwm.reg_gain);
    end
    if (!cfg_reg.global_config.autoscale) tofs_next = cfg_reg.pwm.amplitude_offset; // [RQ11] [RQ15]
    else if (reg_upd && motor_standstill) tofs_next = step8(tofs_reg, up);
    if (!otp_done_reg) tgrad_next = otp_gradient;                  // [RQ12]
    else if (!cfg_reg.global_config.autoscale || !cfg_reg.global_config.autograd)
      tgrad_next = cfg_reg.pwm.amplitude_gradient;                 // [RQ8] [RQ15]
    else if (reg_upd && !motor_standstill) tgrad_next = step8(tgrad_reg, up);
    if (vm_next && !voltage_mode_active) lim_act_next = 1'b1;      // [RQ6]
    else if (fullstep_pulse) lim_act_next = 1'b0;
  end

  // Amplitude: offset plus velocity term, optional regulator scale
  always_comb begin
    osel  = cfg_reg.global_config.autoscale ? tofs_reg : cfg_reg.pwm.amplitude_offset; // [RQ7] [RQ11]
    gsel  = (cfg_reg.global_config.autoscale && cfg_reg.global_config.autograd) ?
            tgrad_reg : cfg_reg.pwm.amplitude_gradient;             // [RQ8] [RQ12]
    gterm = (microstep_interval == '0) ? '0 :
            (20'(gsel) << VEL_SHIFT) / microstep_interval;
    amp_sum = 21'(osel) + 21'(gterm) +
              (cfg_reg.global_config.autoscale ? 21'(scale_reg[8:1]) : 21'h0); // [RQ7]
    amp = (amp_sum > 21'(AMP_MAX)) ? AMP_MAX : amp_sum[7:0];
    if (lim_act_reg && amp > lim_val) amp = lim_val;               // [RQ6]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scale_reg   <= '0;
      tofs_reg    <= OFS_RST;
      tgrad_reg   <= '0;
      lim_act_reg <= 1'b0;
    end else begin
      scale_reg   <= scale_next;
      tofs_reg    <= tofs_next;
      tgrad_reg   <= tgrad_next;
      lim_act_reg <= lim_act_next;
    end
  end

  // ----------------------------------------------------------------
  // PWM period, bridge outputs and comparator blanking
  // ----------------------------------------------------------------
  logic [PER_W-1:0] cnt_reg, cnt_next, per_reg, per_next, duty_reg, duty_next;
  logic [PER_W-1:0] per_sel;
  logic [18:0]      duty_prod;
  logic [5:0]       blank_reg, blank_next, blank_len;
  logic             wrap, pwm_next;

  assign per_sel   = PWM_PER[cfg_reg.pwm.pwm_rate_select];          // [RQ9]
  assign wrap      = (cnt_reg >= per_reg - 11'h001);
  assign duty_prod = 19'(amp) * 19'(per_sel);
  assign blank_len = BLANK_BASE + BLANK_STEP * 6'(cfg_reg.chop.blanking_select); // [RQ17]

  always_comb begin
    cnt_next  = wrap ? '0 : cnt_reg + 11'h001;
    per_next  = per_reg;
    duty_next = duty_reg;
    if (wrap) begin                                                // [RQ18]
      per_next  = per_sel;
      duty_next = duty_prod[18:8];
    end
    pwm_next   = run && (cnt_reg < duty_reg);
    blank_next = (pwm_next != pwm_out) ? blank_len :
                 ((blank_reg != '0) ? blank_reg - 6'h01 : blank_reg); // [RQ17]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg          <= '0;
      per_reg          <= PWM_PER[0];
      duty_reg         <= '0;
      pwm_out          <= 1'b0;
      blank_reg        <= '0;
      comparator_valid <= 1'b0;
      bridge_enable    <= 1'b0;
      low_side_short   <= 1'b0;
      high_side_short  <= 1'b0;
    end else begin
      cnt_reg          <= cnt_next;
      per_reg          <= per_next;
      duty_reg         <= duty_next;
      pwm_out          <= pwm_next;
      blank_reg        <= blank_next;
      comparator_valid <= comparator_raw && (blank_reg == '0);
      bridge_enable    <= drv_en && !applied;                      // [RQ13] [RQ16]
      low_side_short   <= drv_en && applied && cfg_reg.pwm.standstill_option == SS_OPT_LS;
      high_side_short  <= drv_en && applied && cfg_reg.pwm.standstill_option == SS_OPT_HS;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence wb_req_s;  wb_req && !wb_ack_o; endsequence
  sequence wb_done_s; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence ss_arm_s;  ss_reg == SS_RUN ##1 ss_reg == SS_WAIT; endsequence

  wb_ack_timing_a: assert property (wb_req_s |=> wb_done_s)
    else $error("register ack not one cycle after request");
  chop_xor_a: assert property ((cfg_reg.global_config.cur_mode_sel ^ chop_sel_pin) |=> !voltage_mode_active) // [RQ4]
    else $error("voltage mode active despite chopper select");
  speed_gate_a: assert property ((microstep_interval < cfg_reg.speed.limit) |=> !voltage_mode_active) // [RQ5]
    else $error("voltage mode active below speed limit");
  hold_zero_a: assert property ((cfg_reg.hold.hold_current != '0) |=> ss_reg == SS_RUN) // [RQ1]
    else $error("standstill sequence with nonzero hold current");
  delay_wait_a: assert property (ss_arm_s |-> dly_reg == $past(dly_next) ##1 (ss_reg != SS_APPLY || $past(dly_reg) == '0)) // [RQ2]
    else $error("standstill option applied without delay");
  wait_no_short_a: assert property ((ss_reg == SS_WAIT) |=> !low_side_short && !high_side_short) // [RQ2]
    else $error("coil short during standstill delay");
  freeze_zero_a: assert property (target_current_zero |=> $stable(scale_reg)) // [RQ3]
    else $error("regulation moved at zero target current");
  freeze_cm_a: assert property (!voltage_mode_active |=> $stable(scale_reg)) // [RQ14]
    else $error("scale moved in current mode");
  lim_clamp_a: assert property (lim_act_reg |-> amp <= lim_val) // [RQ6]
    else $error("amplitude above switch limit");
  drv_off_a: assert property ((cfg_reg.chop.slow_decay_time == '0) |=> !bridge_enable && !pwm_out) // [RQ16]
    else $error("driver active with zero slow decay time");
  reinit_ofs_a: assert property (!cfg_reg.global_config.autoscale |=> tofs_reg == $past(cfg_reg.pwm.amplitude_offset)) // [RQ15]
    else $error("tuned offset not reloaded");
  blank_load_a: assert property ($changed(pwm_out) |-> blank_reg == $past(blank_len)) // [RQ17]
    else $error("blank time not loaded on switch");
  blank_mask_a: assert property ((blank_reg != '0) |=> !comparator_valid) // [RQ17]
    else $error("comparator passed during blanking");
  period_load_a: assert property (wrap |=> per_reg == $past(per_sel)) // [RQ9] [RQ18]
    else $error("period not taken at period start");

endmodule

`default_nettype wire

/* verif/tb_vmc_chopper_cfg.sv */
// Self-checking bench for the chopper configuration block.
// Assumes the coil model on the motor side and a Wishbone classic master here.
`timescale 1ns/100ps
`default_nettype none
module tb_vmc_chopper_cfg;
  import vmc_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00, otp = 8'h40;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dw = 32'h0, wb_dr, rd;
  logic pin = 1'b0, stand = 1'b0, tzero = 1'b0, fstep, below, cmp;
  logic pwm, bren, lss, hss, vma, cval;
  logic [19:0] ival = 20'h00100;
  int num_errors = 0, cmp_count = 0, cyc_cnt = 0;
  vmc_chopper_cfg vmc_chopper_cfg_i (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dw),
    .wb_dat_o(wb_dr), .wb_ack_o(wb_ack), .chop_sel_pin(pin), .microstep_interval(ival),
    .motor_standstill(stand), .fullstep_pulse(fstep), .target_current_zero(tzero),
    .current_below_target(below), .comparator_raw(cmp), .otp_gradient(otp), .pwm_out(pwm),
    .bridge_enable(bren), .low_side_short(lss), .high_side_short(hss),
    .voltage_mode_active(vma), .comparator_valid(cval));
  vmc_coil_model vmc_coil_model_i (.core_clk(core_clk), .rstn(rstn), .pwm_out(pwm),
    .bridge_enable(bren), .low_side_short(lss), .high_side_short(hss),
    .comparator_raw(cmp), .current_below_target(below), .fullstep_pulse(fstep));
  // Clock and hang guard
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_dw <= d;
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    rd = wb_dr;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    wb_xfer(1'b0, ADR_GLOBAL_CONFIG, 32'h0); check("global_config", rd, 32'h00000006);
    wb_xfer(1'b0, ADR_HOLD, 32'h0);  check("hold", rd, 32'h00140110);
    wb_xfer(1'b0, ADR_PWM, 32'h0);   check("pwm", rd, 32'hc4004024);
    wb_xfer(1'b0, ADR_CHOP, 32'h0);  check("chop", rd, 32'h00000023);
    wb_xfer(1'b0, 8'h3c, 32'h0);     check("unmapped", rd, 32'h0);
    wb_xfer(1'b0, ADR_RDBK, 32'h0);  check("tuned seed", rd[23:8], 16'h4024);
    $display("test reset done");
  endtask
  task automatic t_select();
    logic [1:0] i;
    for (int k = 0; k < 4; k++) begin
      i = 2'(k);
      wb_xfer(1'b1, ADR_GLOBAL_CONFIG, {29'h0, 2'b11, i[1]});
      @(posedge core_clk) pin <= i[0];
      settle(3); check("vmode sel", vma, !(i[1] ^ i[0]));
    end
    $display("test select done");
  endtask
  task automatic t_limit();
    wb_xfer(1'b1, ADR_SPEED, 32'h00000100);
    @(posedge core_clk) ival <= 20'h000ff;
    settle(3); check("vmode fast", vma, 1'b0);
    wb_xfer(1'b0, ADR_STAT, 32'h0); check("limit flag", rd[21:0], {2'b00, 20'h000ff});
    @(posedge core_clk) ival <= 20'h00100;
    settle(3); check("vmode slow", vma, 1'b1);
    wb_xfer(1'b1, ADR_SPEED, 32'h0);
    $display("test limit done");
  endtask
  // Standstill option with powerdown 1 tick, ramp 0
  task automatic t_stand(input logic [1:0] opt, input logic [4:0] hc);
    wb_xfer(1'b1, ADR_PWM, {8'hc4, 2'b00, opt, 4'h0, 16'h4024});
    wb_xfer(1'b1, ADR_HOLD, {16'h0001, 11'h0, hc});
    @(posedge core_clk) stand <= 1'b1;
    tzero <= 1'b1;
    settle(150); check("early short", {lss, hss}, 2'b00);
    settle(150);
    check("ls short", lss, (hc == 5'h0 && opt == SS_OPT_LS));
    check("hs short", hss, (hc == 5'h0 && opt == SS_OPT_HS));
    check("bridge", bren, !(hc == 5'h0 && opt != 2'h0));
    wb_xfer(1'b0, ADR_STAT, 32'h0); check("applied", rd[22], (hc == 5'h0));
    @(posedge core_clk) stand <= 1'b0;
    tzero <= 1'b0;
    settle(4);
    $display("test standstill done");
  endtask
  task automatic t_slow_decay_time();
    wb_xfer(1'b1, ADR_CHOP, 32'h00000020);
    settle(3); check("driver off", bren, 1'b0);
    check("pwm off", pwm, 1'b0);
    wb_xfer(1'b1, ADR_CHOP, 32'h0000002f);
    settle(3); check("driver on", bren, 1'b1);
    $display("test slow decay done");
  endtask
  // Comparator masked 16 clocks after a switching edge, blank code 0
  task automatic t_blank();
    logic p;
    wb_xfer(1'b1, ADR_CHOP, 32'h00000003);
    @(posedge core_clk);
    #1 p = pwm;
    do begin
      @(posedge core_clk);
      #1;
    end while (pwm === p);
    repeat (16) begin
      @(posedge core_clk);
      #1;
      check("blanked", cval, 1'b0);
    end
    $display("test blanking done");
  endtask
  // Clearing autoscale and autograd reloads the tuned values
  task automatic t_reinit();
    wb_xfer(1'b1, ADR_PWM, 32'hc4005a33);
    wb_xfer(1'b1, ADR_GLOBAL_CONFIG, 32'h00000001);
    wb_xfer(1'b0, ADR_RDBK, 32'h0); check("tuned reload", rd[23:8], 16'h5a33);
    $display("test reinit done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_select();
    t_limit();
    for (int k = 0; k < 4; k++) t_stand(2'(k), 5'h00);
    t_stand(SS_OPT_LS, 5'h04);
    t_slow_decay_time();
    t_blank();
    t_reinit();
    stop_test();
  end
endmodule
`default_nettype wire

/* verif/vmc_coil_model.sv */
// Behavioural model of one coil behind the power bridge.
// Assumes registered bridge controls from the chopper block.
`timescale 1ns/100ps
`default_nettype none
module vmc_coil_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic pwm_out,
  input  wire logic bridge_enable,
  input  wire logic low_side_short,
  input  wire logic high_side_short,
  output logic      comparator_raw,
  output logic      current_below_target,
  output logic      fullstep_pulse
);
  logic [7:0] cur_reg;
  logic [5:0] step_reg;
  // Coil current rises while driven, decays otherwise
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_reg  <= 8'h00;
      step_reg <= 6'h00;
    end else begin
      step_reg <= step_reg + 6'h01;
      if (bridge_enable && pwm_out && !low_side_short && !high_side_short && cur_reg != 8'hff)
        cur_reg <= cur_reg + 8'h01;
      else if (cur_reg != 8'h00)
        cur_reg <= cur_reg - 8'h01;
    end
  end
  assign comparator_raw       = cur_reg[7];
  assign current_below_target = !cur_reg[7];
  assign fullstep_pulse       = (step_reg == 6'h3f);
endmodule
`default_nettype wire
